// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import toc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clkEn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_LINES-1:0] pulseIn = 4'h0;
    logic [NUM_LINES-1:0] outLine;
    logic hwAcqTrigPin;
    logic hwFrameTrigPin;
    logic [1:0] intTrig = 2'h0;
    logic [1:0] ready = 2'h0;
    logic [1:0] pinReq = 2'h0;
    logic acqStartFire;
    logic frameStartFire;
    logic irq;
    logic [31:0] rd;
    logic err;
    int lastWidth [NUM_LINES];
    int w [NUM_LINES];
    int mismatches = 0;
    int n_checks = 0;
    int len;
    int d;
    always #2.5 ref_clk = ~ref_clk;
    toc_top dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pulseIn(pulseIn), .outLine(outLine), .hwAcqTrigPin(hwAcqTrigPin),
        .hwFrameTrigPin(hwFrameTrigPin), .intAcqTrig(intTrig[PATH_ACQ]),
        .intFrameTrig(intTrig[PATH_FRM]), .acqStartFire(acqStartFire),
        .frameStartFire(frameStartFire), .readyForAcq(ready[PATH_ACQ]),
        .readyForFrame(ready[PATH_FRM]), .irq(irq)
    );
    toc_line_partner pm_u (
        .ref_clk(ref_clk), .pinReq(pinReq), .hwAcqTrigPin(hwAcqTrigPin),
        .hwFrameTrigPin(hwFrameTrigPin), .outLine(outLine),
        .lastWidth(lastWidth)
    );
    task automatic conclude();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chkReg(input logic [31:0] got, input logic [31:0] e);
        n_checks++;
        if (got !== e) begin
            mismatches++;
            $display("mismatch at %0t: read %h, expected %h", $time, got, e);
        end
    endtask
    task automatic chkTime(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("mismatch at %0t: %0d cycles, not %0d..%0d", $time,
                got, lo, hi);
        end
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [31:0] dat);
        int n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chkReg(32'h0, 32'h1);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dat);
        apb(1'b1, a, dat);
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chkReg(rd, e);
    endtask
    // Source: 0 internal, 1 software, 2 pin; latency in cycles to the fire
    task automatic trig(input logic [CTRL_W-1:0] c, input int path,
        input int src, input int dly);
        int lat = 0;
        int lo;
        wr(OFF_CTRL, 32'(c));
        wr(OFF_TRIG_DELAY, 32'(dly));
        lo = (src == 2) ? 2 : 1;
        if (src == 2 && (path == PATH_ACQ || !c[CTRL_LEGACY])) begin
            lo += dly * int'(US_CYCLES);
        end
        if (src == 1) begin
            rdc(OFF_ACQ_STATUS, 32'h1);
            wr(OFF_SW_TRIG, 32'h1 << path);
        end else begin
            @(posedge ref_clk);
            if (src == 0) intTrig <= 2'h1 << path;
            else pinReq <= 2'h1 << path;
        end
        while (lat < 3000 && (path == PATH_ACQ ? acqStartFire
            : frameStartFire) !== 1'b1) begin
            @(posedge ref_clk);
            lat++;
            if (lat == 1) intTrig <= 2'h0;
        end
        chkTime(lat, lo, lo + 7);
        pinReq <= 2'h0;
        repeat (6) @(posedge ref_clk);
    endtask
    initial begin
        #500us;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        void'($urandom(24));
        for (int i = 0; i < NUM_LINES; i++) begin
            wr(OFF_LINE_SEL, 32'(i));
            rdc(OFF_MIN_WIDTH, 32'h0);
        end
        rdc(OFF_TRIG_DELAY, 32'h0);
        rdc(OFF_IRQ_MASK, 32'h0);
        rdc(8'h24, 32'h0);
        chkReg(32'(err), 32'h1);
        wr(OFF_TRIG_DELAY, 32'h989681);
        rdc(OFF_TRIG_DELAY, 32'(DELAY_MAX_US));
        wr(OFF_MIN_WIDTH, 32'h78);
        rdc(OFF_MIN_WIDTH, 32'(MIN_WIDTH_MAX_US));
        for (int i = 0; i < NUM_LINES; i++) begin
            w[i] = $urandom_range(0, 2);
            wr(OFF_LINE_SEL, 32'(i));
            wr(OFF_MIN_WIDTH, 32'(w[i]));
        end
        for (int i = 0; i < NUM_LINES; i++) begin
            wr(OFF_LINE_SEL, 32'(i));
            rdc(OFF_MIN_WIDTH, 32'(w[i]));
        end
        // Random lengths, then lengths equal to the minimum, or one cycle where the minimum is zero
        for (int r = 0; r < 2 * NUM_LINES; r++) begin
            d = w[r % NUM_LINES] * int'(US_CYCLES);
            len = (r < NUM_LINES) ? $urandom_range(1, 450) : (d > 0 ? d : 1);
            @(posedge ref_clk);
            pulseIn[r % NUM_LINES] <= 1'b1;
            repeat (len) @(posedge ref_clk);
            pulseIn[r % NUM_LINES] <= 1'b0;
            repeat (d + 5) @(posedge ref_clk);
            d = (len > d) ? len : d;
            chkTime(lastWidth[r % NUM_LINES], d, d);
        end
        wr(OFF_STAT_SEL, 32'(STAT_SEL_NONE));
        ready <= 2'h3;
        rdc(OFF_ACQ_STATUS, 32'h0);
        wr(OFF_STAT_SEL, 32'(STAT_SEL_FRAME_WAIT));
        for (int k = 0; k < 8; k++) begin
            wr(OFF_CTRL, 32'(k[2]));
            ready <= 2'(k);
            repeat (2) @(posedge ref_clk);
            rdc(OFF_ACQ_STATUS, 32'(k[2] ? k[0] : k[1]));
        end
        ready <= 2'h3;
        d = $urandom_range(1, 3);
        trig(5'h02, PATH_ACQ, 2, d);
        trig(5'h08, PATH_FRM, 2, d);
        trig(5'h02, PATH_ACQ, 2, 0);
        trig(5'h06, PATH_ACQ, 1, d);
        trig(5'h18, PATH_FRM, 1, d);
        trig(5'h00, PATH_ACQ, 0, d);
        trig(5'h00, PATH_FRM, 0, d);
        trig(5'h03, PATH_ACQ, 2, d);
        trig(5'h09, PATH_FRM, 2, d);
        wr(OFF_IRQ_MASK, 32'h0);
        wr(OFF_IRQ_STATUS, 32'hf);
        trig(5'h00, PATH_ACQ, 0, 0);
        chkReg(32'(irq), 32'h0);
        rdc(OFF_IRQ_STATUS, 32'h1);
        wr(OFF_IRQ_MASK, 32'h1);
        repeat (3) @(posedge ref_clk);
        chkReg(32'(irq), 32'h1);
        wr(OFF_IRQ_STATUS, 32'h1);
        repeat (3) @(posedge ref_clk);
        chkReg(32'(irq), 32'h0);
        rdc(OFF_IRQ_STATUS, 32'h0);
        // Second pin rise while a delay is pending is dropped as overrun
        wr(OFF_CTRL, 32'h2);
        wr(OFF_TRIG_DELAY, 32'h1);
        @(posedge ref_clk);
        pinReq <= 2'h1;
        repeat (10) @(posedge ref_clk);
        pinReq <= 2'h0;
        repeat (10) @(posedge ref_clk);
        pinReq <= 2'h1;
        repeat (10) @(posedge ref_clk);
        pinReq <= 2'h0;
        repeat (300) @(posedge ref_clk);
        rdc(OFF_IRQ_STATUS, 32'h5);
        conclude();
    end
endmodule

// ==== toc_check_assertions.sv ====
`timescale 1ns/1ps
module toc_check
    import toc_pkg::*;
(
    // Clock and control
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Lines and triggers
    input wire logic [NUM_LINES-1:0] pulseIn,
    input wire logic [NUM_LINES-1:0] outLine,
    input wire logic intAcqTrig,
    input wire logic intFrameTrig,
    input wire logic acqStartFire,
    input wire logic frameStartFire
);
    logic [CTRL_W-1:0] ctrl;
    // Mirror of the control word, to know which trigger modes are on
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= CTRL_RST;
        end else if (clkEn && psel && penable && pready && pwrite
            && paddr == OFF_CTRL) begin
            ctrl <= pwdata[CTRL_W-1:0];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n || !clkEn);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_empty_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    access_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("access phase not two cycles");
    line_hold_a: assert property (1 |=>
        ($past(pulseIn) & ~outLine) == 4'h0)
        else $error("output line low while pulse high");
    line_cause_a: assert property (
        (outLine & ~$past(outLine) & ~$past(pulseIn)) == 4'h0)
        else $error("output line rose without pulse");
    acq_single_a: assert property (acqStartFire |=> !acqStartFire)
        else $error("acquisition fire longer than one cycle");
    frm_single_a: assert property (
        frameStartFire |=> !frameStartFire)
        else $error("frame fire longer than one cycle");
    acq_direct_a: assert property (!ctrl[CTRL_ACQ_ON] &&
        intAcqTrig |-> ##[1:2] acqStartFire)
        else $error("internal acquisition trigger not passed");
    frm_direct_a: assert property (!ctrl[CTRL_FRM_ON] &&
        intFrameTrig |-> ##[1:2] frameStartFire)
        else $error("internal frame trigger not passed");
    cover property (acqStartFire);
    cover property (frameStartFire);
    cover property (pslverr);
endmodule
bind toc_top toc_check chk_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulseIn(pulseIn), .outLine(outLine), .intAcqTrig(intAcqTrig),
    .intFrameTrig(intFrameTrig), .acqStartFire(acqStartFire),
    .frameStartFire(frameStartFire)
);

// ==== toc_line_partner.sv ====
`timescale 1ns/1ps
module toc_line_partner
    import toc_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Trigger sources
    input wire logic [1:0] pinReq,
    output logic hwAcqTrigPin,
    output logic hwFrameTrigPin,
    // Output receivers
    input wire logic [NUM_LINES-1:0] outLine,
    output int lastWidth [NUM_LINES]
);
    int run [NUM_LINES];
    initial begin
        hwAcqTrigPin = 1'b0;
        hwFrameTrigPin = 1'b0;
        run = '{default: 0};
        lastWidth = '{default: 0};
    end
    // Pins follow the request one cycle later; widths counted in cycles
    always @(posedge ref_clk) begin
        hwAcqTrigPin <= pinReq[PATH_ACQ];
        hwFrameTrigPin <= pinReq[PATH_FRM];
        for (int i = 0; i < NUM_LINES; i++) begin
            if (outLine[i] === 1'b1) begin
                run[i] <= run[i] + 1;
            end else if (run[i] != 0) begin
                lastWidth[i] <= run[i];
                run[i] <= 0;
            end
        end
    end
endmodule

// ==== toc_pkg.sv ====
package toc_pkg;
    // Timebase
    localparam int CLK_HZ = 200_000_000;
    localparam int HZ_PER_MHZ = 1_000_000;
    localparam logic [7:0] US_CYCLES = 8'(CLK_HZ / HZ_PER_MHZ);

    // Widths
    localparam int NUM_LINES = 4;
    localparam int NUM_PATHS = 2;
    localparam int ADDR_W = 8;
    localparam int MW_W = 7;
    localparam int DL_W = 24;
    localparam int STRETCH_W = 15;
    localparam int CTRL_W = 5;
    localparam int IRQ_W = 4;

    // Limits in microseconds
    localparam logic [MW_W-1:0] MIN_WIDTH_MAX_US = 7'h64;
    localparam logic [DL_W-1:0] DELAY_MAX_US = 24'h989680;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_LINE_SEL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MIN_WIDTH = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_TRIG_DELAY = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STAT_SEL = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_ACQ_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_SW_TRIG = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h20;

    // Control field positions
    localparam int CTRL_LEGACY = 0;
    localparam int CTRL_ACQ_ON = 1;
    localparam int CTRL_ACQ_SW = 2;
    localparam int CTRL_FRM_ON = 3;
    localparam int CTRL_FRM_SW = 4;

    // Path indices, also software trigger and interrupt bit positions
    localparam int PATH_ACQ = 0;
    localparam int PATH_FRM = 1;
    localparam int IRQ_ACQ_FIRE = 0;
    localparam int IRQ_FRM_FIRE = 1;
    localparam int IRQ_ACQ_OVR = 2;
    localparam int IRQ_FRM_OVR = 3;

    // Status selector values
    localparam logic [1:0] STAT_SEL_NONE = 2'h0;
    localparam logic [1:0] STAT_SEL_FRAME_WAIT = 2'h1;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [MW_W-1:0] MIN_WIDTH_RST = 7'h00;
    localparam logic [DL_W-1:0] DELAY_RST = 24'h000000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

    typedef enum logic {
        TOC_TRG_IDLE = 1'b0,
        TOC_TRG_WAIT = 1'b1
    } toc_trg_e;
endpackage

// ==== toc_top.sv ====
`timescale 1ns/1ps
// Operation
// - Pulse shorter than line minimum is stretched to exactly the minimum.
// - Pulse at or above the minimum passes with its width unchanged.
// - Minimum width is set in microseconds, range 0 to 100.
// - Four independent minimum widths; line selector picks the one written.
// - Programmable microsecond delay between hardware trigger and its effect.
// - Trigger delay accepts 0 to 10000000 microseconds.
// - Delay of zero adds no delay to the hardware trigger.
// - Standard mode delays both acquisition start and frame start triggers.
// - No frame delay when frame triggering is off or software sourced.
// - No acquisition delay when acquisition triggering is off or software.
// - Legacy mode delays only acquisition start, never frame start.
// - Standard mode: ready flag true when a frame trigger is accepted.
// - Legacy mode: ready flag true when an acquisition trigger is accepted.
// - Select trigger-wait status before reading flag; same in both modes.
// - No status for the acquisition start command; readiness never from it.
module toc_top
    import toc_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Output lines
    input wire logic [NUM_LINES-1:0] pulseIn,
    output logic [NUM_LINES-1:0] outLine,
    // Trigger inputs
    input wire logic hwAcqTrigPin,
    input wire logic hwFrameTrigPin,
    input wire logic intAcqTrig,
    input wire logic intFrameTrig,
    // Effective triggers
    output logic acqStartFire,
    output logic frameStartFire,
    // Acquisition state
    input wire logic readyForAcq,
    input wire logic readyForFrame,
    // Interrupt
    output logic irq
);

    logic [CTRL_W-1:0] ctrl;
    logic [1:0] lineSel;
    logic [MW_W-1:0] minWidth [NUM_LINES];
    logic [DL_W-1:0] trigDelay;
    logic [1:0] statSel;
    logic acqReadyFlag;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] next_irqStat;
    logic [31:0] rdMux;
    logic doAcc;
    logic doWr;
    logic [NUM_PATHS-1:0] swStrobe;
    logic [NUM_PATHS-1:0] hwPin;
    logic [NUM_PATHS-1:0] intTrig;
    logic [NUM_PATHS-1:0] trigOn;
    logic [NUM_PATHS-1:0] trigSw;
    logic [NUM_PATHS-1:0] trigFire;
    logic [NUM_PATHS-1:0] trigOvr;

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return a == OFF_CTRL || a == OFF_LINE_SEL || a == OFF_MIN_WIDTH ||
            a == OFF_TRIG_DELAY || a == OFF_STAT_SEL ||
            a == OFF_ACQ_STATUS || a == OFF_SW_TRIG ||
            a == OFF_IRQ_STATUS || a == OFF_IRQ_MASK;
    endfunction

    function automatic logic [MW_W-1:0] clampWidth(input logic [31:0] v);
        if (v > 32'(MIN_WIDTH_MAX_US)) begin
            return MIN_WIDTH_MAX_US;
        end
        return v[MW_W-1:0];
    endfunction

    function automatic logic [DL_W-1:0] clampDelay(input logic [31:0] v);
        if (v > 32'(DELAY_MAX_US)) begin
            return DELAY_MAX_US;
        end
        return v[DL_W-1:0];
    endfunction

    // Cycles beyond the first that a stretched pulse must stay high
    function automatic logic [STRETCH_W-1:0] stretchLen(
        input logic [MW_W-1:0] w
    );
        if (w == '0) begin
            return '0;
        end
        return STRETCH_W'(STRETCH_W'(w) * STRETCH_W'(US_CYCLES) - 1'b1);
    endfunction

    // APB: one wait state, answer registered
    assign doAcc = psel & penable & pready;
    assign doWr = doAcc & pwrite;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready <= psel & penable & ~pready;
            // Error flag stands only in the cycle that pready does
            pslverr <= psel & penable & ~pready & ~isMapped(paddr);
            if (psel & penable & ~pready) begin
                prdata <= pwrite ? 32'h00000000 : rdMux;
            end
        end
    end

    always_comb begin
        rdMux = '0;
        if (paddr == OFF_CTRL) begin
            rdMux = 32'(ctrl);
        end else if (paddr == OFF_LINE_SEL) begin
            rdMux = 32'(lineSel);
        end else if (paddr == OFF_MIN_WIDTH) begin
            rdMux = 32'(minWidth[lineSel]);
        end else if (paddr == OFF_TRIG_DELAY) begin
            rdMux = 32'(trigDelay);
        end else if (paddr == OFF_STAT_SEL) begin
            rdMux = 32'(statSel);
        end else if (paddr == OFF_ACQ_STATUS) begin
            rdMux = 32'(acqReadyFlag);
        end else if (paddr == OFF_IRQ_STATUS) begin
            rdMux = 32'(irqStat);
        end else if (paddr == OFF_IRQ_MASK) begin
            rdMux = 32'(irqMask);
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= CTRL_RST;
            lineSel <= 2'h0;
            statSel <= STAT_SEL_NONE;
            irqMask <= IRQ_MASK_RST;
        end else if (clkEn && doWr) begin
            if (paddr == OFF_CTRL) begin
                ctrl <= pwdata[CTRL_W-1:0];
            end else if (paddr == OFF_LINE_SEL) begin
                lineSel <= pwdata[1:0];
            end else if (paddr == OFF_STAT_SEL) begin
                statSel <= pwdata[1:0];
            end else if (paddr == OFF_IRQ_MASK) begin
                irqMask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            trigDelay <= DELAY_RST;
        end else if (clkEn && doWr && paddr == OFF_TRIG_DELAY) begin
            trigDelay <= clampDelay(pwdata);
        end
    end

    // Ready flag only answers under the trigger-wait selection
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            acqReadyFlag <= 1'b0;
        end else if (clkEn) begin
            // Fed only by trigger acceptance, never by start commands
            acqReadyFlag <= (statSel == STAT_SEL_FRAME_WAIT) &&
                (ctrl[CTRL_LEGACY] ? readyForAcq
                                   : readyForFrame);
        end
    end

    // Interrupt status, set wins over write-one-to-clear
    assign irqSet[IRQ_ACQ_FIRE] = trigFire[PATH_ACQ];
    assign irqSet[IRQ_FRM_FIRE] = trigFire[PATH_FRM];
    assign irqSet[IRQ_ACQ_OVR] = trigOvr[PATH_ACQ];
    assign irqSet[IRQ_FRM_OVR] = trigOvr[PATH_FRM];

    always_comb begin
        next_irqStat = irqStat;
        if (doWr && paddr == OFF_IRQ_STATUS) begin
            next_irqStat = irqStat & ~pwdata[IRQ_W-1:0];
        end
        next_irqStat = next_irqStat | irqSet;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqStat <= '0;
            irq <= 1'b0;
        end else if (clkEn) begin
            irqStat <= next_irqStat;
            irq <= |(irqStat & irqMask);
        end
    end

    // Minimum pulse width, one stretcher per output line
    genvar gl;
    generate
        for (gl = 0; gl < NUM_LINES; gl++) begin : g_line
            logic prevIn;
            logic [STRETCH_W-1:0] remain;

            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    minWidth[gl] <= MIN_WIDTH_RST;
                end else if (clkEn && doWr && paddr == OFF_MIN_WIDTH &&
                             lineSel == 2'(gl)) begin
                    minWidth[gl] <= clampWidth(pwdata);
                end
            end

            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    prevIn <= 1'b0;
                    remain <= '0;
                    outLine[gl] <= 1'b0;
                end else if (clkEn) begin
                    prevIn <= pulseIn[gl];
                    if (pulseIn[gl] && !prevIn) begin
                        // Own per-line counter
                        remain <= stretchLen(minWidth[gl]);
                        outLine[gl] <= 1'b1;
                    end else begin
                        if (remain != '0) begin
                            remain <= remain - 1'b1;
                        end
                        // Long pulses follow the input unchanged
                        outLine[gl] <= pulseIn[gl] | (remain != '0);
                    end
                end
            end
        end
    endgenerate

    // Trigger sources per path
    assign hwPin = {hwFrameTrigPin, hwAcqTrigPin};
    assign intTrig = {intFrameTrig, intAcqTrig};
    assign trigOn = {ctrl[CTRL_FRM_ON], ctrl[CTRL_ACQ_ON]};
    assign trigSw = {ctrl[CTRL_FRM_SW], ctrl[CTRL_ACQ_SW]};
    assign swStrobe = (doWr && paddr == OFF_SW_TRIG) ?
        pwdata[NUM_PATHS-1:0] : '0;
    assign acqStartFire = trigFire[PATH_ACQ];
    assign frameStartFire = trigFire[PATH_FRM];

    // Trigger delay, one counter pair per path
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PATHS; gp++) begin : g_path
            logic [2:0] sync;
            logic pinLevel;
            logic hwRise;
            logic applyDelay;
            logic trigEvt;
            logic [DL_W-1:0] usCnt;
            logic [7:0] subCnt;
            toc_trg_e state;

            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync <= 3'h0;
                    pinLevel <= 1'b0;
                end else if (clkEn) begin
                    sync <= {sync[1:0], hwPin[gp]};
                    if (sync[1] == sync[2]) begin
                        pinLevel <= sync[2];
                    end
                end
            end

            assign hwRise = (sync[1] == sync[2]) && sync[2] && !pinLevel;

            // Only a hardware-sourced trigger is delayed
            // Frame path is exempt in legacy mode
            assign applyDelay = trigOn[gp] && !trigSw[gp] &&
                (gp == PATH_ACQ || !ctrl[CTRL_LEGACY]);

            assign trigEvt = trigOn[gp] ?
                (trigSw[gp] ? swStrobe[gp] : hwRise) : intTrig[gp];

            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    state <= TOC_TRG_IDLE;
                    usCnt <= '0;
                    subCnt <= '0;
                    trigFire[gp] <= 1'b0;
                    trigOvr[gp] <= 1'b0;
                end else if (clkEn) begin
                    trigFire[gp] <= 1'b0;
                    trigOvr[gp] <= 1'b0;
                    case (state)
                        TOC_TRG_IDLE: begin
                            if (trigEvt) begin
                                if (applyDelay && trigDelay != '0) begin
                                    state <= TOC_TRG_WAIT;
                                    usCnt <= trigDelay - 1'b1;
                                    subCnt <= US_CYCLES - 1'b1;
                                end else begin
                                    trigFire[gp] <= 1'b1;
                                end
                            end
                        end
                        TOC_TRG_WAIT: begin
                            // A second trigger while waiting is dropped
                            trigOvr[gp] <= trigEvt;
                            if (subCnt != 8'h00) begin
                                subCnt <= subCnt - 1'b1;
                            end else if (usCnt == '0) begin
                                trigFire[gp] <= 1'b1;
                                state <= TOC_TRG_IDLE;
                            end else begin
                                usCnt <= usCnt - 1'b1;
                                subCnt <= US_CYCLES - 1'b1;
                            end
                        end
                        default: begin
                            state <= TOC_TRG_IDLE;
                        end
                    endcase
                end
            end
        end
    endgenerate

endmodule
